// [src/psc_host.sv]
// Host end: runs enter/leave sequences for one power-managed function
//
// Added by the designer: the plain strobed port and the address map.
`include "psc_map.svh"

module psc_host
	import psc_pkg::*;
#(
	parameter int unsigned RESUME_CYC = `PSC_RESUME_CYC,
	parameter int unsigned SEGRST_CYC = `PSC_SEGRST_CYC
) (
	input wire logic clk,
	input wire logic srst,
	psc_if.host bus,
	input wire logic [3:0] sw_addr,
	input wire logic [31:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [31:0] sw_rdata,
	input wire logic pending_txn,
	input wire logic peer_active,
	input wire logic bus_low_req,
	output logic bus_low_grant,
	output logic dsi_init_req,
	input wire logic dsi_init_done
);
	psc_hstate_t st_reg;
	psc_dstate_t cur_reg;
	psc_dstate_t tgt_reg;
	logic wen_reg;
	logic [10:0] save_reg;
	logic busy_reg;
	logic done_reg;
	logic refused_reg;
	logic dsi_reg;
	logic [31:0] dly_reg;
	logic [31:0] sw_rdata_reg;
	logic [7:0] addr_reg;
	logic [31:0] wdata_reg;
	logic wr_reg;
	logic rd_reg;
	logic segrst_reg;
	logic go;
	logic sup;

	assign go = sw_wr && sw_addr == `PSC_HOFS_CTRL
		&& sw_wdata[`PSC_HCTRL_GO_BIT] && st_reg == PSC_H_IDLE;

	// Support check against the capability word just read
	always_comb begin
		case (tgt_reg)
			PSC_D1: sup = bus.cfg_rdata[`PSC_CAPS_D1_BIT];
			PSC_D2: sup = bus.cfg_rdata[`PSC_CAPS_D2_BIT];
			default: sup = 1'b1;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			tgt_reg <= PSC_D0;
			wen_reg <= 1'b0;
			save_reg <= 11'h000;
		end else if (sw_wr && st_reg == PSC_H_IDLE) begin
			if (sw_addr == `PSC_HOFS_CTRL) begin
				tgt_reg <= psc_dstate_t'(sw_wdata[1:0]);
				wen_reg <= sw_wdata[`PSC_HCTRL_WEN_BIT];
			end else if (sw_addr == `PSC_HOFS_SAVE) begin
				save_reg <= sw_wdata[10:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_reg <= PSC_H_IDLE;
			cur_reg <= PSC_D0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			refused_reg <= 1'b0;
			dsi_reg <= 1'b0;
			dly_reg <= 32'h0000_0000;
			addr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wr_reg <= 1'b0;
			rd_reg <= 1'b0;
			segrst_reg <= 1'b0;
		end else begin
			wr_reg <= 1'b0;
			rd_reg <= 1'b0;
			case (st_reg)
				PSC_H_IDLE: begin
					if (go) begin
						busy_reg <= 1'b1;
						done_reg <= 1'b0;
						refused_reg <= 1'b0;
						st_reg <= PSC_H_CAPS_RD;
					end
				end
				PSC_H_CAPS_RD: begin
					// [R06] Read capabilities first
					addr_reg <= `PSC_OFS_CAPS;
					rd_reg <= 1'b1;
					st_reg <= PSC_H_CAPS_CHK;
				end
				PSC_H_CAPS_CHK: begin
					if (!rd_reg) begin
						dsi_reg <= bus.cfg_rdata[`PSC_CAPS_DSI_BIT];
						// [R06] Never request unsupported
						if (!sup) begin
							refused_reg <= 1'b1;
							busy_reg <= 1'b0;
							st_reg <= PSC_H_IDLE;
						end else if (tgt_reg == PSC_D0 && cur_reg == PSC_D3) begin
							dly_reg <= 32'h0000_0000;
							st_reg <= PSC_H_SEG_RST;
						end else if (tgt_reg != PSC_D0) begin
							st_reg <= PSC_H_DRAIN;
						end else begin
							st_reg <= PSC_H_WR_PM;
						end
					end
				end
				PSC_H_DRAIN: begin
					// [R07] No pending transactions
					// [R08] Peer traffic stopped
					if (!pending_txn && !peer_active) begin
						st_reg <= tgt_reg == PSC_D3 ? PSC_H_OFF_CMD : PSC_H_WR_PM;
					end
				end
				PSC_H_OFF_CMD: begin
					// [R10] Clear enables before D3
					addr_reg <= `PSC_OFS_CMD;
					wdata_reg <= 32'h0000_0000;
					wr_reg <= 1'b1;
					st_reg <= PSC_H_WR_PM;
				end
				PSC_H_WR_PM: begin
					addr_reg <= `PSC_OFS_CTLSTS;
					wdata_reg <= {23'h00_0000, wen_reg, 6'h00, tgt_reg};
					wr_reg <= 1'b1;
					dly_reg <= 32'h0000_0000;
					st_reg <= tgt_reg == PSC_D0 ? PSC_H_DELAY : PSC_H_RB_RD;
				end
				PSC_H_DELAY: begin
					// [R11] Settle before first access
					if (dly_reg >= 32'(RESUME_CYC) - 32'h0000_0001) begin
						st_reg <= PSC_H_RB_RD;
					end else begin
						dly_reg <= dly_reg + 32'h0000_0001;
					end
				end
				PSC_H_SEG_RST: begin
					// [R12] Segment reset after power
					segrst_reg <= 1'b1;
					if (dly_reg >= 32'(SEGRST_CYC) - 32'h0000_0001) begin
						segrst_reg <= 1'b0;
						st_reg <= PSC_H_WAIT_RDY;
					end else begin
						dly_reg <= dly_reg + 32'h0000_0001;
					end
				end
				PSC_H_WAIT_RDY: begin
					if (bus.cfg_ready && !segrst_reg) begin
						st_reg <= PSC_H_RST_CMD;
					end
				end
				PSC_H_RST_CMD: begin
					// [R13] Restore enables
					addr_reg <= `PSC_OFS_CMD;
					wdata_reg <= {29'h0000_0000, save_reg[2:0]};
					wr_reg <= 1'b1;
					st_reg <= PSC_H_RST_INT;
				end
				PSC_H_RST_INT: begin
					// [R13] Restore interrupt line
					addr_reg <= `PSC_OFS_INTLN;
					wdata_reg <= {24'h00_0000, save_reg[10:3]};
					wr_reg <= 1'b1;
					st_reg <= PSC_H_DSI;
				end
				PSC_H_DSI: begin
					// [R14] Specific init when flagged
					if (!dsi_reg || dsi_init_done) begin
						st_reg <= PSC_H_RB_RD;
					end
				end
				PSC_H_RB_RD: begin
					addr_reg <= `PSC_OFS_CTLSTS;
					rd_reg <= 1'b1;
					st_reg <= PSC_H_RB_CHK;
				end
				PSC_H_RB_CHK: begin
					if (!rd_reg) begin
						cur_reg <= psc_dstate_t'(bus.cfg_rdata[1:0]);
						if (bus.cfg_rdata[1:0] == tgt_reg) begin
							done_reg <= 1'b1;
							busy_reg <= 1'b0;
							st_reg <= PSC_H_IDLE;
						end else begin
							st_reg <= PSC_H_RB_RD;
						end
					end
				end
				default: st_reg <= PSC_H_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			sw_rdata_reg <= 32'h0000_0000;
		end else if (sw_rd && sw_addr == `PSC_HOFS_STAT) begin
			sw_rdata_reg <= {24'h00_0000, !bus.wake_event_out_n, dsi_reg,
				cur_reg, refused_reg, done_reg, busy_reg, 1'b0};
		end else if (sw_rd && sw_addr == `PSC_HOFS_CTRL) begin
			sw_rdata_reg <= {28'h000_0000, wen_reg, 1'b0, tgt_reg};
		end else if (sw_rd && sw_addr == `PSC_HOFS_SAVE) begin
			sw_rdata_reg <= {21'h00_0000, save_reg};
		end else begin
			sw_rdata_reg <= 32'h0000_0000;
		end
	end

	assign sw_rdata = sw_rdata_reg;
	assign bus.cfg_addr = addr_reg;
	assign bus.cfg_wdata = wdata_reg;
	assign bus.cfg_wr = wr_reg;
	assign bus.cfg_rd = rd_reg;
	assign bus.seg_rst = segrst_reg;
	assign dsi_init_req = st_reg == PSC_H_DSI && dsi_reg;
	// [R09] Bus low only when function sleeps
	assign bus_low_grant = bus_low_req && cur_reg != PSC_D0
		&& st_reg == PSC_H_IDLE;
endmodule

// [src/psc_map.svh]
// Offsets, field positions, reset values and timing counts of the block
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH

`define PSC_CLK_MHZ 100
// Device configuration word offsets
`define PSC_OFS_CAPS 8'h00
`define PSC_OFS_CTLSTS 8'h04
`define PSC_OFS_CMD 8'h08
`define PSC_OFS_INTLN 8'h0C
// Capability register fields
`define PSC_CAPS_VER_LSB 0
`define PSC_CAPS_DSI_BIT 5
`define PSC_CAPS_D1_BIT 9
`define PSC_CAPS_D2_BIT 10
`define PSC_CAPS_WAKE_LSB 11
`define PSC_CAPS_WCOLD_BIT 15
// Control and status register fields
`define PSC_CS_STATE_LSB 0
`define PSC_CS_WEN_BIT 8
`define PSC_CS_WSTS_BIT 15
// Command register fields
`define PSC_CMD_IO_BIT 0
`define PSC_CMD_MEM_BIT 1
`define PSC_CMD_MST_BIT 2
`define PSC_RST_WORD 32'h0000_0000
// Host command port offsets
`define PSC_HOFS_CTRL 4'h0
`define PSC_HOFS_SAVE 4'h4
`define PSC_HOFS_STAT 4'h8
`define PSC_HCTRL_GO_BIT 2
`define PSC_HCTRL_WEN_BIT 3
// Timing: ready after segment reset, internal transition, resume delays
`define PSC_INIT_MS 10
`define PSC_INIT_CYC (`PSC_INIT_MS * `PSC_CLK_MHZ * 1000)
`define PSC_TRANS_NS 1000
`define PSC_TRANS_CYC (`PSC_TRANS_NS * `PSC_CLK_MHZ / 1000)
`define PSC_RESUME_US 10
`define PSC_RESUME_CYC (`PSC_RESUME_US * `PSC_CLK_MHZ)
`define PSC_SEGRST_NS 1000
`define PSC_SEGRST_CYC (`PSC_SEGRST_NS * `PSC_CLK_MHZ / 1000)

`endif

// [src/psc_pkg.sv]
// Types shared by both ends of the power-state control link
package psc_pkg;
	typedef enum logic [1:0] {PSC_D0, PSC_D1, PSC_D2, PSC_D3} psc_dstate_t;
	typedef enum logic [3:0] {
		PSC_H_IDLE, PSC_H_CAPS_RD, PSC_H_CAPS_CHK, PSC_H_DRAIN,
		PSC_H_OFF_CMD, PSC_H_WR_PM, PSC_H_DELAY, PSC_H_SEG_RST,
		PSC_H_WAIT_RDY, PSC_H_RST_CMD, PSC_H_RST_INT, PSC_H_DSI,
		PSC_H_RB_RD, PSC_H_RB_CHK
	} psc_hstate_t;
endpackage

// [src/psc_if.sv]
// Configuration link between host bridge and power-managed function
interface psc_if (
	input wire logic clk
);
	logic [7:0] cfg_addr;
	logic [31:0] cfg_wdata;
	logic cfg_wr;
	logic cfg_rd;
	logic [31:0] cfg_rdata;
	logic cfg_ready;
	logic seg_rst;
	logic wake_event_out_n_o;
	logic wake_event_out_oe_n;
	logic wake_event_out_n;

	// Open-drain wake line, pulled high when nobody drives it
	assign wake_event_out_n = wake_event_out_oe_n ? 1'b1 : wake_event_out_n_o;

	modport dev (
		input cfg_addr, cfg_wdata, cfg_wr, cfg_rd, seg_rst,
		output cfg_rdata, cfg_ready, wake_event_out_n_o, wake_event_out_oe_n
	);
	modport host (
		output cfg_addr, cfg_wdata, cfg_wr, cfg_rd, seg_rst,
		input cfg_rdata, cfg_ready, wake_event_out_n
	);
endinterface

// [src/psc_dev.sv]
// Function end: power capability, control/status and command registers
`include "psc_map.svh"

// Overview of operation
// [R01] Unsupported state write completes, data dropped
// [R02] State field reads actual current state
// [R03] Specific-init flag at capability bit five
// [R04] Set init flag only with compatibility mode
// [R05] Wake enable gates the wake line
// [R06] Host reads capabilities, requests supported only
// [R07] Host drains pending transactions before D1-D3
// [R08] Host stops peer traffic before sleeping
// [R09] Bus low only after functions sleep
// [R10] Host clears decode enables before D3
// [R11] Host waits after D1/D2 resume write
// [R12] Cold recovery: power, then segment reset
// [R13] Host restores full context after D3; host restores only enables and interrupt line, not wake enable
// [R14] Host runs specific init when flagged
// [R15] Reset release initialises to uninitialised D0
// [R16] Accept cycles within 10 ms after reset
// [R17] Status updates only after change completes
// [R18] Two-bit state encoding, resets to D0
module psc_dev
	import psc_pkg::*;
#(
	parameter int unsigned INIT_CYC = `PSC_INIT_CYC,
	parameter int unsigned TRANS_CYC = `PSC_TRANS_CYC,
	parameter bit SUP_D1 = 1'b1,
	parameter bit SUP_D2 = 1'b1,
	parameter bit NEEDS_INIT = 1'b0,
	parameter logic [2:0] CAPS_VER = 3'h3,
	parameter logic [4:0] WAKE_FROM = 5'h1F
) (
	input wire logic clk,
	input wire logic srst,
	psc_if.dev bus,
	input wire logic wake_req,
	input wire logic aux_present,
	output logic [1:0] dev_state,
	output logic dev_ready,
	output logic io_en,
	output logic mem_en,
	output logic master_en
);
	psc_dstate_t state_reg;
	psc_dstate_t pend_reg;
	logic trans_reg;
	logic [31:0] trans_cnt_reg;
	logic [31:0] init_cnt_reg;
	logic ready_reg;
	logic wen_reg;
	logic wsts_reg;
	logic [2:0] cmd_reg;
	logic [7:0] intln_reg;
	logic [31:0] rdata_reg;
	logic [31:0] caps_word;
	logic [31:0] cs_word;
	logic vol_rst;
	logic wr_cs;
	logic req_ok;
	logic [1:0] req_state;

	// A segment reset clears all volatile logic like the bus reset
	assign vol_rst = srst | bus.seg_rst;
	assign wr_cs = bus.cfg_wr && ready_reg && bus.cfg_addr == `PSC_OFS_CTLSTS;
	assign req_state = bus.cfg_wdata[`PSC_CS_STATE_LSB +: 2];

	// Legal targets: D0 and D3 always, D1/D2 by option
	always_comb begin
		case (req_state)
			2'h1: req_ok = SUP_D1;
			2'h2: req_ok = SUP_D2;
			default: req_ok = 1'b1;
		endcase
	end

	// [R03] Init flag placement
	always_comb begin
		caps_word = `PSC_RST_WORD;
		caps_word[`PSC_CAPS_VER_LSB +: 3] = CAPS_VER;
		// [R04] Flag from option
		caps_word[`PSC_CAPS_DSI_BIT] = NEEDS_INIT;
		caps_word[`PSC_CAPS_D1_BIT] = SUP_D1;
		caps_word[`PSC_CAPS_D2_BIT] = SUP_D2;
		caps_word[`PSC_CAPS_WAKE_LSB +: 5] = WAKE_FROM;
		// Wake from cold only claimed when aux power is really there
		caps_word[`PSC_CAPS_WCOLD_BIT] = WAKE_FROM[4] & aux_present;
	end

	// [R02] Field shows committed state
	always_comb begin
		cs_word = `PSC_RST_WORD;
		cs_word[`PSC_CS_STATE_LSB +: 2] = state_reg;
		cs_word[`PSC_CS_WEN_BIT] = wen_reg;
		cs_word[`PSC_CS_WSTS_BIT] = wsts_reg;
	end

	// [R16] Ready count after reset release
	always_ff @(posedge clk) begin
		if (vol_rst) begin
			init_cnt_reg <= 32'h0000_0000;
			ready_reg <= 1'b0;
		end else if (!ready_reg) begin
			if (init_cnt_reg >= 32'(INIT_CYC) - 32'h0000_0001) begin
				ready_reg <= 1'b1;
			end else begin
				init_cnt_reg <= init_cnt_reg + 32'h0000_0001;
			end
		end
	end

	// [R15] Reset release enters uninitialised D0
	always_ff @(posedge clk) begin
		if (vol_rst) begin
			// [R18] Reset to D0
			state_reg <= PSC_D0;
			pend_reg <= PSC_D0;
			trans_reg <= 1'b0;
			trans_cnt_reg <= 32'h0000_0000;
		end else if (wr_cs && req_ok) begin
			// A newer request replaces one still in progress
			pend_reg <= psc_dstate_t'(req_state);
			trans_reg <= psc_dstate_t'(req_state) != state_reg;
			trans_cnt_reg <= 32'h0000_0000;
		end else if (trans_reg) begin
			// [R17] Commit only once done
			if (trans_cnt_reg >= 32'(TRANS_CYC) - 32'h0000_0001) begin
				state_reg <= pend_reg;
				trans_reg <= 1'b0;
			end else begin
				trans_cnt_reg <= trans_cnt_reg + 32'h0000_0001;
			end
		end
	end

	// [R01] Unsupported write dropped whole
	always_ff @(posedge clk) begin
		if (vol_rst) begin
			wen_reg <= 1'b0;
		end else if (wr_cs && req_ok) begin
			wen_reg <= bus.cfg_wdata[`PSC_CS_WEN_BIT];
		end
	end

	// Wake status is write-one-to-clear; a new event wins over the clear
	always_ff @(posedge clk) begin
		if (vol_rst) begin
			wsts_reg <= 1'b0;
		end else if (wake_req) begin
			wsts_reg <= 1'b1;
		end else if (wr_cs && req_ok && bus.cfg_wdata[`PSC_CS_WSTS_BIT]) begin
			wsts_reg <= 1'b0;
		end
	end

	// Decode enables and interrupt line
	always_ff @(posedge clk) begin
		if (vol_rst) begin
			cmd_reg <= 3'h0;
			intln_reg <= 8'h00;
		end else if (bus.cfg_wr && ready_reg) begin
			if (bus.cfg_addr == `PSC_OFS_CMD) begin
				cmd_reg <= bus.cfg_wdata[2:0];
			end else if (bus.cfg_addr == `PSC_OFS_INTLN) begin
				intln_reg <= bus.cfg_wdata[7:0];
			end
		end
	end

	// Read data one cycle after the strobe; zero while not ready
	always_ff @(posedge clk) begin
		if (vol_rst) begin
			rdata_reg <= `PSC_RST_WORD;
		end else if (bus.cfg_rd && ready_reg) begin
			if (bus.cfg_addr == `PSC_OFS_CAPS) begin
				rdata_reg <= caps_word;
			end else if (bus.cfg_addr == `PSC_OFS_CTLSTS) begin
				rdata_reg <= cs_word;
			end else if (bus.cfg_addr == `PSC_OFS_CMD) begin
				rdata_reg <= {29'h0000_0000, cmd_reg};
			end else if (bus.cfg_addr == `PSC_OFS_INTLN) begin
				rdata_reg <= {24'h00_0000, intln_reg};
			end else begin
				rdata_reg <= `PSC_RST_WORD;
			end
		end else begin
			rdata_reg <= `PSC_RST_WORD;
		end
	end

	assign bus.cfg_rdata = rdata_reg;
	assign bus.cfg_ready = ready_reg;
	// [R05] Wake line gated
	assign bus.wake_event_out_oe_n = !(wsts_reg && wen_reg);
	assign bus.wake_event_out_n_o = 1'b0;
	assign dev_state = state_reg;
	assign dev_ready = ready_reg;
	// Decoding is off in every low-power state whatever the enables say
	assign io_en = cmd_reg[`PSC_CMD_IO_BIT] && state_reg == PSC_D0;
	assign mem_en = cmd_reg[`PSC_CMD_MEM_BIT] && state_reg == PSC_D0;
	assign master_en = cmd_reg[`PSC_CMD_MST_BIT] && state_reg == PSC_D0;
endmodule

// [dv/psc_monitor.sv]
// Checker for the host-to-function configuration link
`include "psc_map.svh"

module psc_monitor
	import psc_pkg::*;
#(
	parameter int unsigned INIT_CYC = 20,
	parameter bit SUP_D1 = 1'b1,
	parameter bit SUP_D2 = 1'b1,
	parameter bit NEEDS_INIT = 1'b0
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [7:0] cfg_addr,
	input wire logic [31:0] cfg_wdata,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [31:0] cfg_rdata,
	input wire logic cfg_ready,
	input wire logic seg_rst,
	input wire logic wake_event_out_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] cnt_reg;
	logic wen_reg;
	logic [2:0] cmd_reg;
	logic ok_st;
	logic rd_ok;
	logic wr_ok;

	assign rd_ok = cfg_rd && cfg_ready;
	assign wr_ok = cfg_wr && cfg_ready;
	assign ok_st = (cfg_wdata[1:0] == 2'b01) ? SUP_D1
		: (cfg_wdata[1:0] == 2'b10) ? SUP_D2 : 1'b1;

	// Edges since either reset let go; saturates so it never wraps
	always_ff @(posedge clk) begin
		if (srst || seg_rst) begin
			cnt_reg <= 16'h0000;
		end else if (cnt_reg != 16'hffff) begin
			cnt_reg <= cnt_reg + 16'h0001;
		end
	end

	// Shadow of the wake enable, dropped with refused state words
	always_ff @(posedge clk) begin
		if (srst || seg_rst) begin
			wen_reg <= 1'b0;
		end else if (wr_ok && cfg_addr == `PSC_OFS_CTLSTS && ok_st) begin
			wen_reg <= cfg_wdata[`PSC_CS_WEN_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (srst || seg_rst) begin
			cmd_reg <= 3'b000;
		end else if (wr_ok && cfg_addr == `PSC_OFS_CMD) begin
			cmd_reg <= cfg_wdata[2:0];
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	sequence quiet4;
		!(cfg_wr || cfg_rd) [*4];
	endsequence
	sequence seg_hold;
		seg_rst [*4];
	endsequence

	caps_bits_a: assert property (
		$past(rd_ok) && $past(cfg_addr) == `PSC_OFS_CAPS |->
		cfg_rdata[5] == NEEDS_INIT && cfg_rdata[9] == SUP_D1
		&& cfg_rdata[10] == SUP_D2)
		else $error("capability bits wrong");
	state_valid_a: assert property (
		$past(rd_ok) && $past(cfg_addr) == `PSC_OFS_CTLSTS |->
		(cfg_rdata[1:0] != 2'b01 || SUP_D1)
		&& (cfg_rdata[1:0] != 2'b10 || SUP_D2))
		else $error("unsupported state read back");
	wake_gate_a: assert property (
		!wake_event_out_oe_n |-> wen_reg || $past(wen_reg))
		else $error("wake line driven while disabled");
	ready_clear_a: assert property (
		seg_rst |=> !cfg_ready)
		else $error("ready kept through segment reset");
	ready_late_a: assert property (
		!cfg_ready |-> cnt_reg < INIT_CYC)
		else $error("ready came late");
	ready_early_a: assert property (
		cfg_ready |-> cnt_reg >= INIT_CYC)
		else $error("ready came early");
	d3_cmd_off_a: assert property (
		cfg_wr && cfg_addr == `PSC_OFS_CTLSTS && cfg_wdata[1:0] == 2'b11
		|-> cmd_reg == 3'b000)
		else $error("D3 entered with decoders on");
	resume_gap_a: assert property (
		cfg_wr && cfg_addr == `PSC_OFS_CTLSTS && cfg_wdata[1:0] == 2'b00
		|=> quiet4)
		else $error("access too soon after resume");
	segrst_len_a: assert property (
		$rose(seg_rst) |-> seg_hold)
		else $error("segment reset too short");
endmodule

// [dv/tb_top.sv]
// Bench: host and function joined, plus a second function driven directly
`include "psc_map.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk;
	logic srst;
	logic [3:0] sw_addr;
	logic [31:0] sw_wdata;
	logic sw_wr;
	logic sw_rd;
	logic [31:0] sw_rdata;
	logic pending_txn;
	logic peer_active;
	logic bus_low_req;
	logic bus_low_grant;
	logic dsi_init_done;
	logic dsi_init_req;
	logic aux_present;
	logic wake_req;
	logic wake_req_b;
	logic [1:0] dev_state;
	logic [1:0] state_b;
	logic io_en;
	logic mem_en;
	logic master_en;
	logic [31:0] d;
	logic m_wen;
	int fail_count;
	int checks;
	int cycles;
	int seed;
	int n;
	int st;
	int m_state;

	psc_if h_if (.clk(clk));
	psc_if b_if (.clk(clk));

	psc_host i_psc_host (
		.clk(clk), .srst(srst), .bus(h_if), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
		.sw_rdata(sw_rdata), .pending_txn(pending_txn),
		.peer_active(peer_active), .bus_low_req(bus_low_req),
		.bus_low_grant(bus_low_grant), .dsi_init_req(dsi_init_req),
		.dsi_init_done(dsi_init_done)
	);
	psc_dev #(.INIT_CYC(20), .NEEDS_INIT(1'b1)) i_psc_dev (
		.clk(clk), .srst(srst), .bus(h_if), .wake_req(wake_req),
		.aux_present(aux_present), .dev_state(dev_state), .dev_ready(),
		.io_en(io_en), .mem_en(mem_en), .master_en(master_en)
	);
	psc_dev #(.INIT_CYC(20), .SUP_D2(1'b0)) i_psc_dev_b (
		.clk(clk), .srst(srst), .bus(b_if), .wake_req(wake_req_b),
		.aux_present(aux_present), .dev_state(state_b), .dev_ready(),
		.io_en(), .mem_en(), .master_en()
	);
	psc_monitor #(.NEEDS_INIT(1'b1)) i_psc_monitor (
		.clk(clk), .srst(srst), .cfg_addr(h_if.cfg_addr),
		.cfg_wdata(h_if.cfg_wdata), .cfg_wr(h_if.cfg_wr),
		.cfg_rd(h_if.cfg_rd), .cfg_rdata(h_if.cfg_rdata),
		.cfg_ready(h_if.cfg_ready), .seg_rst(h_if.seg_rst),
		.wake_event_out_oe_n(h_if.wake_event_out_oe_n)
	);

	task automatic final_report;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic sw_write(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk);
		sw_addr <= a;
		sw_wdata <= v;
		sw_wr <= 1'b1;
		@(posedge clk);
		sw_wr <= 1'b0;
	endtask

	task automatic sw_read(input logic [3:0] a, output logic [31:0] v);
		@(posedge clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge clk);
		sw_rd <= 1'b0;
		#1 v = sw_rdata;
	endtask

	task automatic cfg_write(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		b_if.cfg_addr <= a;
		b_if.cfg_wdata <= v;
		b_if.cfg_wr <= 1'b1;
		@(posedge clk);
		b_if.cfg_wr <= 1'b0;
	endtask

	task automatic cfg_read(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		b_if.cfg_addr <= a;
		b_if.cfg_rd <= 1'b1;
		@(posedge clk);
		b_if.cfg_rd <= 1'b0;
		#1 v = b_if.cfg_rdata;
	endtask

	// Poll until the host is idle, then expect done in the target state
	task automatic host_wait(input logic [1:0] t);
		logic [31:0] s;
		s = 32'h0000_0002;
		n = 0;
		while (s[1] !== 1'b0 && n < 1000) begin
			sw_read(`PSC_HOFS_STAT, s);
			n++;
		end
		check("host status", (32'(t) << 4) | 32'h0000_0004, s & 32'h0000_003e);
	endtask

	task automatic wake_pulse(input logic b);
		@(posedge clk);
		if (b) wake_req_b <= 1'b1;
		else wake_req <= 1'b1;
		@(posedge clk);
		wake_req_b <= 1'b0;
		wake_req <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			$display("[ERR] run time expected done seen hang");
			final_report();
		end
	end

	initial begin
		srst = 1'b1;
		{sw_addr, sw_wdata, sw_wr, sw_rd, pending_txn, peer_active} = '0;
		{wake_req, wake_req_b} = 2'b00;
		bus_low_req = 1'b1;
		dsi_init_done = 1'b1;
		aux_present = 1'b0;
		{b_if.cfg_addr, b_if.cfg_wdata, b_if.cfg_wr, b_if.cfg_rd} = '0;
		b_if.seg_rst = 1'b0;
		seed = 32'h0000_95e4;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		n = 0;
		while ((h_if.cfg_ready !== 1'b1 || b_if.cfg_ready !== 1'b1) && n < 100) begin
			@(posedge clk);
			n++;
		end
		#1 check("ready time", 32'h0000_0001, 32'(n <= 22));
		check("reset state", 32'h0000_0000, 32'(dev_state));
		check("grant in D0", 32'h0000_0000, 32'(bus_low_grant));
		cfg_read(`PSC_OFS_CAPS, d);
		check("caps", 32'h0000_0200, d & 32'h0000_8620);
		cfg_read(8'h10, d);
		check("unmapped cfg", 32'h0000_0000, d);
		aux_present <= 1'b1;
		cfg_read(`PSC_OFS_CAPS, d);
		check("caps aux", 32'h0000_8200, d & 32'h0000_8620);
		m_state = 0;
		m_wen = 1'b0;
		for (int i = 0; i < 10; i++) begin
			st = (i < 4) ? (i + 1) % 4 : $random(seed) & 3;
			d = $random(seed);
			// A refused state word must leave the wake enable alone
			if (st != 2) m_wen = d[0];
			cfg_write(`PSC_OFS_CTLSTS, 32'(st) | (32'(d[0]) << 8));
			cfg_read(`PSC_OFS_CTLSTS, d);
			check("state early", m_state, 32'(d[1:0]));
			check("wake enable", 32'(m_wen), 32'(d[8]));
			if (st != 2) m_state = st;
			repeat (`PSC_TRANS_CYC) @(posedge clk);
			cfg_read(`PSC_OFS_CTLSTS, d);
			check("state", m_state, 32'(d[1:0]));
			check("dev state", m_state, 32'(state_b));
		end
		cfg_write(`PSC_OFS_CTLSTS, 32'(m_state));
		wake_pulse(1'b1);
		check("wake off", 32'h0000_0001, 32'(b_if.wake_event_out_n));
		cfg_write(`PSC_OFS_CTLSTS, 32'(m_state) | 32'h0000_0100);
		repeat (2) @(posedge clk);
		#1 check("wake on", 32'h0000_0000, 32'(b_if.wake_event_out_n));
		cfg_write(`PSC_OFS_CTLSTS, 32'(m_state) | 32'h0000_8100);
		repeat (2) @(posedge clk);
		#1 check("wake clear", 32'h0000_0001, 32'(b_if.wake_event_out_n));
		sw_read(4'hc, d);
		check("unmapped sw", 32'h0000_0000, d);
		sw_write(`PSC_HOFS_SAVE, 32'h0000_02d7);
		pending_txn <= 1'b1;
		sw_write(`PSC_HOFS_CTRL, 32'h0000_000d);
		repeat (20) @(posedge clk);
		check("held by pending", 32'h0000_0000, 32'(dev_state));
		pending_txn <= 1'b0;
		host_wait(2'b01);
		check("in D1", 32'h0000_0001, 32'(dev_state));
		check("grant in D1", 32'h0000_0001, 32'(bus_low_grant));
		wake_pulse(1'b0);
		check("host wake", 32'h0000_0000, 32'(h_if.wake_event_out_n));
		sw_write(`PSC_HOFS_CTRL, 32'h0000_000c);
		host_wait(2'b00);
		peer_active <= 1'b1;
		sw_write(`PSC_HOFS_CTRL, 32'h0000_000f);
		repeat (20) @(posedge clk);
		check("held by peer", 32'h0000_0000, 32'(dev_state));
		peer_active <= 1'b0;
		host_wait(2'b11);
		check("in D3", 32'h0000_0003, 32'(dev_state));
		// Hold back the init-done answer so the host must wait for it
		dsi_init_done <= 1'b0;
		sw_write(`PSC_HOFS_CTRL, 32'h0000_000c);
		n = 0;
		while (dsi_init_req !== 1'b1 && n < 1000) begin
			@(posedge clk);
			n++;
		end
		repeat (10) @(posedge clk);
		sw_read(`PSC_HOFS_STAT, d);
		check("dsi wait", 32'h0000_0042, d & 32'h0000_0042);
		dsi_init_done <= 1'b1;
		host_wait(2'b00);
		check("cold exit", 32'h0000_0000, 32'(dev_state));
		check("restored", 32'h0000_0007, 32'({master_en, mem_en, io_en}));
		check("int line", 32'h0000_005a, 32'(i_psc_dev.intln_reg));
		// Enables are on now, so the host must clear them first
		sw_write(`PSC_HOFS_CTRL, 32'h0000_000f);
		host_wait(2'b11);
		check("D3 enables", 32'h0, 32'({master_en, mem_en, io_en}));
		final_report();
	end
endmodule
